/* src/oscsw_pkg.sv */
// constants for the oscillator source select and warm-up block
package oscsw_pkg;

    localparam logic [7:0]  ADDR_CLOCK_SOURCE_CONTROL = 8'hC4;
    localparam logic [7:0]  ADDR_OSCILLATOR_STATUS    = 8'hC5;

    localparam logic [7:0]  CLOCK_SOURCE_CONTROL_RESET = 8'h81;
    localparam logic [7:0]  OSCILLATOR_STATUS_RESET    = 8'h00;

    // clock_source_control fields
    localparam int          BIT_CRYSTAL_SELECT    = 7;
    localparam int          BIT_RC_MODE_FLAG      = 6;
    localparam int          BIT_RESUME_RC_SELECT  = 5;
    localparam int          BIT_SUB_OSC_DISABLE   = 4;
    localparam int          BIT_MAIN_OSC_DISABLE  = 3;
    localparam int          BIT_ALWAYS_ONE        = 0;

    // oscillator_status fields
    localparam int          BIT_SUB_OSC_READY     = 5;
    localparam int          BIT_MAIN_OSC_READY    = 4;

    localparam int          WARM_W                = 17;
    localparam logic [16:0] MAIN_WARMUP_SHORT     = 17'h01000;
    localparam logic [16:0] SUB_WARMUP_SHORT      = 17'h00400;
    localparam logic [16:0] WARMUP_LONG_DEFAULT   = 17'h10000;

endpackage

/* src/oscsw_osc_if.sv */
// link between the controller and one oscillator warm-up tracker
`timescale 1ns/1ps
interface oscsw_osc_if;
    logic run;
    logic restart;
    logic level;
    logic ready;

    modport warm (
        input  run,
        input  restart,
        output level,
        output ready
    );

    modport ctrl (
        output run,
        output restart,
        input  level,
        input  ready
    );
endinterface

/* src/oscsw_warmup.sv */
// warm-up tracker: synchronises an oscillator pin and counts its rising edges
`timescale 1ns/1ps
module oscsw_warmup #(
    parameter logic [16:0] TARGET         = 17'h10000,
    parameter logic        READY_AT_RESET = 1'b0
) (
    input  wire logic     clock,
    input  wire logic     nrst,
    input  wire logic     osc_pin,
    oscsw_osc_if.warm     port
);
    logic                        sync_a;
    logic                        sync_b;
    logic                        level_d;
    logic [oscsw_pkg::WARM_W-1:0] count;
    logic                        ready_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync_a  <= 1'b0;
            sync_b  <= 1'b0;
            level_d <= 1'b0;
        end else begin
            sync_a  <= osc_pin;
            sync_b  <= sync_a;
            level_d <= sync_b;
        end
    end

    // count oscillator clocks while running; a stop or restart starts over
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else if (!port.run || port.restart) begin
            count <= '0;
        end else if (sync_b && !level_d && count != TARGET) begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ready_q <= READY_AT_RESET;
        end else if (!port.run || port.restart) begin
            ready_q <= 1'b0;
        end else if (count == TARGET) begin
            ready_q <= 1'b1;
        end
    end

    assign port.level = sync_b;
    assign port.ready = ready_q;
endmodule

/* src/oscsw_clk_switch.sv */
// safe-point source selector between crystal and RC oscillator
`timescale 1ns/1ps
module oscsw_clk_switch (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic want_xtal,
    input  wire logic xtal_level,
    input  wire logic xtal_running,
    input  wire logic rc_pin,
    output logic      sel_xtal
);
    logic rc_sync_a;
    logic rc_sync_b;
    logic safe;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rc_sync_a <= 1'b0;
            rc_sync_b <= 1'b0;
        end else begin
            rc_sync_a <= rc_pin;
            rc_sync_b <= rc_sync_a;
        end
    end

    // both clocks low: neither phase can be cut short; a stopped crystal is safe
    assign safe = !rc_sync_b && (!xtal_level || !xtal_running);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sel_xtal <= 1'b1;
        end else if (want_xtal != sel_xtal && safe) begin
            sel_xtal <= want_xtal;
        end
    end
endmodule

/* src/oscsw_top.sv */
// system clock source control: register pair, power-down resume, warm-up flags
`timescale 1ns/1ps
module oscsw_top #(
    parameter logic [16:0] MAIN_WARMUP_LONG = oscsw_pkg::WARMUP_LONG_DEFAULT,
    parameter logic [16:0] SUB_WARMUP_LONG  = oscsw_pkg::WARMUP_LONG_DEFAULT,
    parameter logic        MAIN_OPT_LONG    = 1'b1,
    parameter logic        SUB_OPT_LONG     = 1'b0
) (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic [7:0]      sfr_rdata,
    input  wire logic       power_down,
    input  wire logic       xtal_osc_pin,
    input  wire logic       sub_osc_pin,
    input  wire logic       rc_osc_pin,
    output logic            main_osc_enable,
    output logic            sub_osc_enable,
    output logic            sys_clk_xtal,
    output logic            cpu_hold
);
    // warm-up lengths fixed by option, not by register
    localparam logic [16:0] MAIN_TARGET =
        MAIN_OPT_LONG ? MAIN_WARMUP_LONG : oscsw_pkg::MAIN_WARMUP_SHORT;
    localparam logic [16:0] SUB_TARGET =
        SUB_OPT_LONG ? SUB_WARMUP_LONG : oscsw_pkg::SUB_WARMUP_SHORT;
    localparam logic [7:0]  CTRL_RESET = oscsw_pkg::CLOCK_SOURCE_CONTROL_RESET;

    logic       crystal_select;
    logic       resume_rc_select;
    logic       sub_osc_disable;
    logic       main_osc_disable;
    logic       always_one;
    logic       rc_mode_flag;
    logic       main_osc_ready;
    logic       sub_osc_ready;
    logic       pd_d;
    logic       pd_exit;
    logic       wr_ctrl;
    logic [7:0] ctrl_rd;
    logic [7:0] status_rd;
    logic       sel_xtal;

    oscsw_osc_if main_if ();
    oscsw_osc_if sub_if ();

    assign wr_ctrl = sfr_wr && sfr_addr == oscsw_pkg::ADDR_CLOCK_SOURCE_CONTROL;
    assign pd_exit = pd_d && !power_down;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pd_d <= 1'b0;
        end else begin
            pd_d <= power_down;
        end
    end

    // crystal select: set only with a warm, enabled crystal; resume on RC forces it off
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            crystal_select <= CTRL_RESET[oscsw_pkg::BIT_CRYSTAL_SELECT];
        end else if (pd_exit && resume_rc_select) begin
            crystal_select <= 1'b0;
        end else if (wr_ctrl) begin
            if (!sfr_wdata[oscsw_pkg::BIT_CRYSTAL_SELECT]) begin
                crystal_select <= 1'b0;
            end else if (main_osc_ready && !main_osc_disable
                         && !sfr_wdata[oscsw_pkg::BIT_MAIN_OSC_DISABLE]) begin
                // a write that also stops the crystal must not select it
                crystal_select <= 1'b1;
            end
        end
    end

    // crystal disable: a one sticks only while the core runs from RC
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            main_osc_disable <= CTRL_RESET[oscsw_pkg::BIT_MAIN_OSC_DISABLE];
        end else if (wr_ctrl) begin
            if (!sfr_wdata[oscsw_pkg::BIT_MAIN_OSC_DISABLE]) begin
                main_osc_disable <= 1'b0;
            end else if (rc_mode_flag) begin
                main_osc_disable <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            resume_rc_select <= CTRL_RESET[oscsw_pkg::BIT_RESUME_RC_SELECT];
            sub_osc_disable  <= CTRL_RESET[oscsw_pkg::BIT_SUB_OSC_DISABLE];
            always_one       <= CTRL_RESET[oscsw_pkg::BIT_ALWAYS_ONE];
        end else if (wr_ctrl) begin
            resume_rc_select <= sfr_wdata[oscsw_pkg::BIT_RESUME_RC_SELECT];
            sub_osc_disable  <= sfr_wdata[oscsw_pkg::BIT_SUB_OSC_DISABLE];
            // stored as written; software is expected to keep it one
            always_one       <= sfr_wdata[oscsw_pkg::BIT_ALWAYS_ONE];
        end
    end

    // crystal tracker: stopped when disabled or in power-down, restarted on exit
    assign main_if.run     = !main_osc_disable && !power_down;
    assign main_if.restart = pd_exit;
    assign main_osc_ready  = main_if.ready;

    oscsw_warmup #(
        .TARGET         (MAIN_TARGET),
        .READY_AT_RESET (1'b1)
    ) u_main_warm (
        .clock   (clock),
        .nrst    (nrst),
        .osc_pin (xtal_osc_pin),
        .port    (main_if.warm)
    ); // ready clears when stopped or restarted reads one after reset

    assign sub_if.run     = !sub_osc_disable;
    assign sub_if.restart = 1'b0;
    assign sub_osc_ready  = sub_if.ready;

    oscsw_warmup #(
        .TARGET         (SUB_TARGET),
        .READY_AT_RESET (1'b0)
    ) u_sub_warm (
        .clock   (clock),
        .nrst    (nrst),
        .osc_pin (sub_osc_pin),
        .port    (sub_if.warm)
    );

    oscsw_clk_switch u_switch (
        .clock        (clock),
        .nrst         (nrst),
        .want_xtal    (crystal_select),
        .xtal_level   (main_if.level),
        .xtal_running (main_if.run),
        .rc_pin       (rc_osc_pin),
        .sel_xtal     (sel_xtal)
    );

    // source actually driving the core
    assign rc_mode_flag = !sel_xtal;
    assign sys_clk_xtal = sel_xtal;

    // resume hold: on crystal resume wait for warm-up, on RC resume run at once
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cpu_hold <= 1'b0;
        end else if (pd_exit) begin
            cpu_hold <= !resume_rc_select;
        end else if (cpu_hold && main_osc_ready) begin
            cpu_hold <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            main_osc_enable <= 1'b1;
            sub_osc_enable  <= 1'b1;
        end else begin
            main_osc_enable <= !main_osc_disable && !power_down;
            sub_osc_enable  <= !sub_osc_disable;
        end
    end

    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[oscsw_pkg::BIT_CRYSTAL_SELECT]   = crystal_select;
        ctrl_rd[oscsw_pkg::BIT_RC_MODE_FLAG]     = rc_mode_flag;
        ctrl_rd[oscsw_pkg::BIT_RESUME_RC_SELECT] = resume_rc_select;
        ctrl_rd[oscsw_pkg::BIT_SUB_OSC_DISABLE]  = sub_osc_disable;
        ctrl_rd[oscsw_pkg::BIT_MAIN_OSC_DISABLE] = main_osc_disable;
        ctrl_rd[oscsw_pkg::BIT_ALWAYS_ONE]       = always_one;
        status_rd = oscsw_pkg::OSCILLATOR_STATUS_RESET;
        status_rd[oscsw_pkg::BIT_SUB_OSC_READY]  = sub_osc_ready;
        status_rd[oscsw_pkg::BIT_MAIN_OSC_READY] = main_osc_ready;
    end

    // read data registered on the read strobe; unmapped addresses read zero
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                oscsw_pkg::ADDR_CLOCK_SOURCE_CONTROL: sfr_rdata <= ctrl_rd;
                oscsw_pkg::ADDR_OSCILLATOR_STATUS:    sfr_rdata <= status_rd;
                default:                              sfr_rdata <= 8'h00;
            endcase
        end
    end
endmodule

/* bench/oscsw_osc_model.sv */
// behavioural crystal, sub and rc oscillators
`timescale 1ns/1ps
module oscsw_osc_model (
    input  wire logic main_osc_enable,
    input  wire logic sub_osc_enable,
    output logic      xtal_osc_pin,
    output logic      sub_osc_pin,
    output logic      rc_osc_pin
);
    initial begin
        xtal_osc_pin = 1'b0;
        sub_osc_pin = 1'b0;
        rc_osc_pin = 1'b0;
    end
    // a stopped oscillator rests low
    always #200 xtal_osc_pin = main_osc_enable ? ~xtal_osc_pin : 1'b0;
    always #300 sub_osc_pin = sub_osc_enable ? ~sub_osc_pin : 1'b0;
    // half period chosen so no rc edge lands on a rising clock edge
    always #220 rc_osc_pin = ~rc_osc_pin;
endmodule

/* bench/oscsw_top_assertions.sv */
// port checks of the oscillator source control
`timescale 1ns/1ps
module oscsw_chk (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       power_down,
    input wire logic       main_osc_enable,
    input wire logic       sub_osc_enable,
    input wire logic       sys_clk_xtal,
    input wire logic       cpu_hold
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    wire ctl_wr = sfr_wr && sfr_addr == 8'hC4;
    xtal_needs_osc_a: assert property ($rose(sys_clk_xtal) |-> main_osc_enable)
        else $error("crystal picked while stopped");
    stop_on_rc_a: assert property ($fell(main_osc_enable)
        |-> !sys_clk_xtal || $past(power_down)) else $error("crystal stopped while in use");
    stop_refused_a: assert property (ctl_wr && sfr_wdata[3] && sys_clk_xtal
        && main_osc_enable && !power_down |=> main_osc_enable)
        else $error("crystal stop not refused");
    pd_stops_a: assert property (power_down |=> !main_osc_enable)
        else $error("crystal runs in pd");
    sub_stop_a: assert property (ctl_wr && sfr_wdata[4] |-> ##[1:2] !sub_osc_enable)
        else $error("sub oscillator not stopped");
    hold_cause_a: assert property ($rose(cpu_hold)
        |-> $past(power_down, 2) || $past(power_down, 3)) else $error("hold without pd exit");
    hold_bound_a: assert property ($rose(cpu_hold) |-> ##[1:300] !cpu_hold)
        else $error("hold never ends");
    rc_flag_read_a: assert property (sfr_rd && sfr_addr == 8'hC4
        |=> sfr_rdata[6] == !$past(sys_clk_xtal) && sfr_rdata[2:1] == 2'b00)
        else $error("rc flag wrong");
    cover property ($rose(cpu_hold));
    cover property ($fell(sys_clk_xtal));
    cover property ($fell(sub_osc_enable));
endmodule
bind oscsw_top oscsw_chk u_chk (.clock(clock), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .power_down(power_down),
    .main_osc_enable(main_osc_enable), .sub_osc_enable(sub_osc_enable),
    .sys_clk_xtal(sys_clk_xtal), .cpu_hold(cpu_hold));

/* bench/oscsw_top_tb.sv */
// self-checking bench for the oscillator source control
`timescale 1ns/1ps
module oscsw_top_tb;
    logic       clock, nrst, sfr_wr, sfr_rd, power_down, xp, sp, rp, m_en, s_en, xtal, hold;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    int         num_errors, num_checks;

    oscsw_top #(.MAIN_WARMUP_LONG(17'h00008), .SUB_WARMUP_LONG(17'h00008),
        .MAIN_OPT_LONG(1'b1), .SUB_OPT_LONG(1'b1)) u_dut (.clock(clock), .nrst(nrst),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .power_down(power_down), .xtal_osc_pin(xp), .sub_osc_pin(sp),
        .rc_osc_pin(rp), .main_osc_enable(m_en), .sub_osc_enable(s_en), .sys_clk_xtal(xtal),
        .cpu_hold(hold));
    oscsw_osc_model u_osc (.main_osc_enable(m_en), .sub_osc_enable(s_en), .xtal_osc_pin(xp),
        .sub_osc_pin(sp), .rc_osc_pin(rp));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = w;
        sfr_rd = !w;
        @(posedge clock);
        #1;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
    endtask
    task automatic rdm(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        access(1'b0, a, 8'h00);
        chk(sfr_rdata & m, exp);
    endtask
    task automatic wait_out(input logic sel, input logic v);
        for (int n = 0; n < 300 && (sel ? hold : xtal) !== v; n++) @(posedge clock);
        #1;
        chk({7'h00, sel ? hold : xtal}, {7'h00, v});
    endtask
    task automatic pd_cycle;
        power_down = 1'b1;
        repeat (5) @(posedge clock);
        #1;
        power_down = 1'b0;
    endtask
    task automatic end_of_test;
        if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #(3000 * 100);
        num_errors++;
        end_of_test;
    end

    initial begin
        {nrst, sfr_wr, sfr_rd, power_down, sfr_addr, sfr_wdata} = '0;
        repeat (6) @(posedge clock);
        #1;
        nrst = 1'b1;
        rdm(8'hC4, 8'h81, 8'hFF);
        rdm(8'hC5, 8'h10, 8'hFF);
        rdm(8'hC6, 8'h00, 8'hFF);
        repeat (100) @(posedge clock);
        rdm(8'hC5, 8'h30, 8'hFF);
        access(1'b1, 8'hC4, 8'h89);
        rdm(8'hC4, 8'h81, 8'hFF);
        access(1'b1, 8'hC4, 8'h01);
        wait_out(1'b0, 1'b0);
        rdm(8'hC4, 8'h41, 8'hFF);
        repeat (10) @(posedge clock);
        access(1'b1, 8'hC4, 8'h09);
        rdm(8'hC5, 8'h20, 8'hFF);
        chk({7'h00, m_en}, 8'h00);
        access(1'b1, 8'hC4, 8'h89);
        rdm(8'hC4, 8'h49, 8'hFF);
        access(1'b1, 8'hC4, 8'h01);
        access(1'b1, 8'hC4, 8'h81);
        rdm(8'hC4, 8'h41, 8'hFF);
        repeat (100) @(posedge clock);
        rdm(8'hC5, 8'h30, 8'hFF);
        access(1'b1, 8'hC4, 8'h89);
        rdm(8'hC4, 8'h49, 8'hFF);
        access(1'b1, 8'hC4, 8'h01);
        repeat (100) @(posedge clock);
        access(1'b1, 8'hC4, 8'h81);
        wait_out(1'b0, 1'b1);
        rdm(8'hC4, 8'h81, 8'hFF);
        access(1'b1, 8'hC4, 8'h91);
        rdm(8'hC5, 8'h10, 8'hFF);
        chk({7'h00, s_en}, 8'h00);
        access(1'b1, 8'hC4, 8'h81);
        repeat (100) @(posedge clock);
        rdm(8'hC5, 8'h30, 8'hFF);
        pd_cycle;
        wait_out(1'b1, 1'b1);
        rdm(8'hC5, 8'h00, 8'h10);
        wait_out(1'b1, 1'b0);
        rdm(8'hC5, 8'h10, 8'h10);
        access(1'b1, 8'hC4, 8'hA1);
        pd_cycle;
        repeat (3) @(posedge clock);
        #1;
        chk({7'h00, hold}, 8'h00);
        wait_out(1'b0, 1'b0);
        rdm(8'hC4, 8'h61, 8'hFF);
        end_of_test;
    end
endmodule
